// ### bench/cfg_endpoint_model.sv
// register endpoint model answering access requests with done, status and read data
`timescale 1ns/1ps
`default_nettype none
module cfg_endpoint_model (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic acc_valid_in,
    input wire cfg_msg_pkg::acc_req_t acc_req_in,
    input wire logic fail_in,
    input wire logic slow_in,
    output logic acc_done_out,
    output logic acc_ok_out,
    output logic [31:0] acc_rdata_out
);
    logic [31:0] mem_reg [16];
    cfg_msg_pkg::acc_req_t req_reg;
    logic busy_reg;
    logic [1:0] wait_reg;

    // outside the done cycle status and data keep changing, so stale values never match by luck
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_reg <= 1'b0;
            wait_reg <= 2'h0;
            acc_done_out <= 1'b0;
            acc_ok_out <= 1'b0;
            acc_rdata_out <= 32'h5A5A_5A5A;
        end else begin
            acc_done_out <= 1'b0;
            acc_ok_out <= ~acc_ok_out;
            acc_rdata_out <= ~acc_rdata_out;
            if (acc_valid_in) begin
                busy_reg <= 1'b1;
                req_reg <= acc_req_in;
                wait_reg <= slow_in ? 2'h3 : 2'h0;
            end else if (busy_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                acc_done_out <= 1'b1;
                acc_ok_out <= ~fail_in;
                acc_rdata_out <= mem_reg[req_reg.reg_num[3:0]];
                if (!fail_in && req_reg.write) begin
                    mem_reg[req_reg.reg_num[3:0]] <= req_reg.wdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/cfg_msg_access_bench.sv
// self-checking bench for the configuration message interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module cfg_msg_access_bench;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic rx_valid_in = 1'b0;
    cfg_msg_pkg::token_t rx_tok_in = '0;
    cfg_msg_pkg::space_t rx_space_in = cfg_msg_pkg::SPACE_TILE;
    logic tx_ready_in = 1'b0;
    logic ps_cmd_valid_in = 1'b0;
    logic ps_cmd_write_in = 1'b0;
    logic [31:0] ps_cmd_resid_in = '0;
    logic [31:0] ps_cmd_wdata_in = '0;
    logic fail = 1'b0;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic rx_ready_out, tx_valid_out, acc_valid_out, acc_done_in, acc_ok_in, ps_valid_out, ps_bad_out;
    cfg_msg_pkg::token_t tx_tok_out;
    logic [23:0] tx_dest_out;
    logic [23:0] last_dest;
    cfg_msg_pkg::acc_req_t acc_req_out;
    logic [31:0] acc_rdata_in;
    cfg_msg_pkg::ps_req_t ps_req_out;
    cfg_msg_pkg::token_t rq[$];
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    cfg_msg_access i_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .rx_valid_in(rx_valid_in),
        .rx_tok_in(rx_tok_in), .rx_space_in(rx_space_in), .rx_ready_out(rx_ready_out),
        .tx_valid_out(tx_valid_out), .tx_tok_out(tx_tok_out), .tx_dest_out(tx_dest_out),
        .tx_ready_in(tx_ready_in), .acc_valid_out(acc_valid_out), .acc_req_out(acc_req_out),
        .acc_done_in(acc_done_in), .acc_ok_in(acc_ok_in), .acc_rdata_in(acc_rdata_in),
        .ps_cmd_valid_in(ps_cmd_valid_in), .ps_cmd_write_in(ps_cmd_write_in),
        .ps_cmd_resid_in(ps_cmd_resid_in), .ps_cmd_wdata_in(ps_cmd_wdata_in),
        .ps_valid_out(ps_valid_out), .ps_bad_out(ps_bad_out), .ps_req_out(ps_req_out));
    cfg_endpoint_model i_model (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .acc_valid_in(acc_valid_out), .acc_req_in(acc_req_out), .fail_in(fail), .slow_in(slow),
        .acc_done_out(acc_done_in), .acc_ok_out(acc_ok_in), .acc_rdata_out(acc_rdata_in));

    always #5 core_clk_in = ~core_clk_in;
    // a stalling sink makes every reply token after the first stand over two edges
    always @(posedge core_clk_in) tx_ready_in <= stall ? ~tx_ready_in : 1'b1;
    always @(posedge core_clk_in) begin
        if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
            rq.push_back(tx_tok_out);
            last_dest = tx_dest_out;
        end
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic send(input logic c, input logic [7:0] d);
        rx_valid_in <= 1'b1;
        rx_tok_in <= {c, d};
        do @(posedge core_clk_in); while (rx_ready_out !== 1'b1);
    endtask

    // opening token, reply id and n field bytes, all most significant byte first
    task automatic msg(input logic [7:0] op, input cfg_msg_pkg::space_t sp, input logic [23:0] id,
        input logic [47:0] fld, input int n);
        @(posedge core_clk_in);
        rx_space_in <= sp;
        send(1'b1, op);
        for (int i = 0; i < 3; i++) send(1'b0, id[8*(2-i) +: 8]);
        for (int i = 0; i < n; i++) send(1'b0, fld[8*(n-1-i) +: 8]);
        send(1'b1, cfg_msg_pkg::TOK_END);
        rx_valid_in <= 1'b0;
    endtask

    // waits until the parser is idle again, then judges the n reply tokens
    task automatic reply(input int n, input logic [47:0] exp, input logic [23:0] id);
        int k;
        logic cf;
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (k < 80 && !(rq.size() == n && rx_ready_out === 1'b1));
        `CHECK(rq.size(), n)
        for (int i = 0; i < n && i < rq.size(); i++) begin
            cf = (i == 0 || i == n - 1);
            `CHECK(rq[i], {cf, exp[8*(n-1-i) +: 8]})
        end
        if (n > 0) `CHECK(last_dest, id)
        rq.delete();
    endtask

    task automatic t_write_read();
        slow <= 1'b1;
        msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SPACE_TILE, 24'h01_0203, 48'h0005_1122_3344, 6);
        reply(2, 48'h0301, 24'h01_0203);
        stall <= 1'b1;
        msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SPACE_NODE, 24'h04_0506, 48'h0005, 2);
        reply(6, 48'h0311_2233_4401, 24'h04_0506);
        slow <= 1'b0;
    endtask

    task automatic t_noreply();
        msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SPACE_NODE, 24'h01_02FF, 48'h0006_A5A5_0F0F, 6);
        reply(0, 48'h0, 24'h0);
        msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SPACE_PERIPH, 24'h07_0809, 48'h0604, 2);
        reply(6, 48'h03A5_A50F_0F01, 24'h07_0809);
    endtask

    task automatic t_periph();
        msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SPACE_PERIPH, 24'h0A_0B0C, 48'h0502, 2);
        reply(4, 48'h0333_4401, 24'h0A_0B0C);
        msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SPACE_PERIPH, 24'h0A_0B0D, 48'h0500, 2);
        reply(2, 48'h0401, 24'h0A_0B0D);
        msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SPACE_PERIPH, 24'h0A_0B0E, 48'h0505, 2);
        reply(2, 48'h0401, 24'h0A_0B0E);
    endtask

    task automatic t_fail();
        fail <= 1'b1;
        msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SPACE_TILE, 24'h02_0304, 48'h0007_0000_0001, 6);
        reply(2, 48'h0401, 24'h02_0304);
        msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SPACE_TILE, 24'h02_0305, 48'h0005, 2);
        reply(2, 48'h0401, 24'h02_0305);
        fail <= 1'b0;
        msg(8'h55, cfg_msg_pkg::SPACE_TILE, 24'h03_0405, 48'h0005, 2);
        reply(2, 48'h0401, 24'h03_0405);
        msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SPACE_TILE, 24'h03_0406, 48'h0501, 2);
        reply(2, 48'h0401, 24'h03_0406);
    endtask

    // cut reply id is dropped silently; stray control or extra bytes fail the request
    task automatic t_malformed();
        @(posedge core_clk_in);
        rx_space_in <= cfg_msg_pkg::SPACE_NODE;
        send(1'b1, cfg_msg_pkg::TOK_WRITE);
        send(1'b0, 8'h01);
        send(1'b1, cfg_msg_pkg::TOK_END);
        rx_valid_in <= 1'b0;
        reply(0, 48'h0, 24'h0);
        msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SPACE_NODE, 24'h05_0607, 48'h00, 1);
        reply(2, 48'h0401, 24'h05_0607);
        msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SPACE_TILE, 24'h05_0608, 48'h00_0500, 3);
        reply(2, 48'h0401, 24'h05_0608);
    endtask

    task automatic ps(input logic w, input logic [31:0] rid, input logic ok);
        @(posedge core_clk_in);
        ps_cmd_valid_in <= 1'b1;
        ps_cmd_write_in <= w;
        ps_cmd_resid_in <= rid;
        ps_cmd_wdata_in <= 32'hCAFE_0123;
        @(posedge core_clk_in);
        ps_cmd_valid_in <= 1'b0;
        @(posedge core_clk_in);
        `CHECK(ps_valid_out, ok)
        `CHECK(ps_bad_out, ~ok)
        if (ok) `CHECK(ps_req_out, {w, rid[31:8], 32'hCAFE_0123})
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        t_write_read();
        t_noreply();
        t_periph();
        t_fail();
        t_malformed();
        ps(1'b1, 32'h0000_120B, 1'b1);
        ps(1'b0, 32'h0000_340A, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### src/cfg_msg_access.sv
// configuration message interpreter: parses request tokens, runs the access, sends the reply
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - write whose reply id low byte is all ones gets no reply.
// - multi-byte fields travel most significant byte first, both directions.
// - status resource id holds register number above bit 7, type 0x0B low.
// - status read and write instructions move exactly one 32-bit word.
// - config write: token 192, reply id, 16-bit register, 32-bit data, token 1.
// - config read: token 193, reply id, 16-bit register, token 1.
// - write reply is tokens 3,1 on success, 4,1 on failure.
// - read reply is token 3, 32-bit value, token 1; else 4,1.
// - peripheral read: 37, reply id, register, size, 1; reply 3,data,1 or 4,1.
module cfg_msg_access (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic rx_valid_in,
    input wire cfg_msg_pkg::token_t rx_tok_in,
    input wire cfg_msg_pkg::space_t rx_space_in,
    output logic rx_ready_out,
    output logic tx_valid_out,
    output cfg_msg_pkg::token_t tx_tok_out,
    output logic [23:0] tx_dest_out,
    input wire logic tx_ready_in,
    output logic acc_valid_out,
    output cfg_msg_pkg::acc_req_t acc_req_out,
    input wire logic acc_done_in,
    input wire logic acc_ok_in,
    input wire logic [31:0] acc_rdata_in,
    input wire logic ps_cmd_valid_in,
    input wire logic ps_cmd_write_in,
    input wire logic [31:0] ps_cmd_resid_in,
    input wire logic [31:0] ps_cmd_wdata_in,
    output logic ps_valid_out,
    output logic ps_bad_out,
    output cfg_msg_pkg::ps_req_t ps_req_out
);
    cfg_msg_pkg::state_t state_reg;
    cfg_msg_pkg::space_t space_reg;
    logic [23:0] rid_reg;
    logic [15:0] reg_num_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [7:0] size_reg;
    logic [2:0] cnt_reg;
    logic [2:0] tx_left_reg;
    logic write_reg;
    logic bad_reg;
    logic mute_reg;
    logic ok_reg;
    logic tx_valid_reg;
    cfg_msg_pkg::token_t tx_tok_reg;
    logic acc_valid_reg;
    logic rx_fire;
    logic tx_fire;
    logic is_end;
    logic periph;
    logic [2:0] reply_len;

    function automatic logic [31:0] push_byte(input logic [31:0] w, input logic [7:0] b);
        return {w[23:0], b};
    endfunction

    function automatic logic [31:0] align_top(input logic [31:0] w, input logic [2:0] n);
        logic [5:0] sh;
        sh = {3'(cfg_msg_pkg::WORD_BYTES - n), 3'b000};
        return w << sh;
    endfunction

    assign rx_ready_out = (state_reg == cfg_msg_pkg::ST_IDLE) || (state_reg == cfg_msg_pkg::ST_RID)
        || (state_reg == cfg_msg_pkg::ST_REG) || (state_reg == cfg_msg_pkg::ST_SIZE)
        || (state_reg == cfg_msg_pkg::ST_DATA) || (state_reg == cfg_msg_pkg::ST_END)
        || (state_reg == cfg_msg_pkg::ST_SKIP);
    assign rx_fire = rx_valid_in && rx_ready_out;
    assign tx_fire = tx_valid_reg && tx_ready_in;
    assign is_end = rx_tok_in.ctrl && (rx_tok_in.data == cfg_msg_pkg::TOK_END);
    assign periph = (space_reg == cfg_msg_pkg::SPACE_PERIPH);
    // peripheral reads return only the requested bytes
    assign reply_len = periph ? size_reg[2:0] : cfg_msg_pkg::WORD_BYTES;
    assign tx_valid_out = tx_valid_reg;
    assign tx_tok_out = tx_tok_reg;
    assign tx_dest_out = rid_reg;
    assign acc_valid_out = acc_valid_reg;

    // request parsing and reply sequencing
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= cfg_msg_pkg::ST_IDLE;
            space_reg <= cfg_msg_pkg::SPACE_NONE;
            cnt_reg <= '0;
            write_reg <= 1'b0;
            bad_reg <= 1'b0;
            mute_reg <= 1'b0;
            ok_reg <= 1'b0;
            tx_left_reg <= '0;
            tx_valid_reg <= 1'b0;
            tx_tok_reg <= '0;
            acc_valid_reg <= 1'b0;
        end else begin
            acc_valid_reg <= 1'b0;
            case (state_reg)
                cfg_msg_pkg::ST_IDLE: begin
                    // stray data tokens between messages are dropped
                    if (rx_fire && rx_tok_in.ctrl) begin
                        space_reg <= rx_space_in;
                        cnt_reg <= '0;
                        mute_reg <= 1'b0;
                        write_reg <= (rx_tok_in.data == cfg_msg_pkg::TOK_WRITE);
                        if (((rx_tok_in.data == cfg_msg_pkg::TOK_WRITE || rx_tok_in.data == cfg_msg_pkg::TOK_READ)
                                && (rx_space_in == cfg_msg_pkg::SPACE_TILE
                                || rx_space_in == cfg_msg_pkg::SPACE_NODE))
                                || (rx_tok_in.data == cfg_msg_pkg::TOK_PREAD
                                && rx_space_in == cfg_msg_pkg::SPACE_PERIPH)) begin
                            bad_reg <= 1'b0;
                        end else begin
                            bad_reg <= 1'b1;
                        end
                        state_reg <= cfg_msg_pkg::ST_RID;
                    end
                end
                cfg_msg_pkg::ST_RID: begin
                    if (rx_fire && rx_tok_in.ctrl) begin
                        // no complete reply id, so nobody can be answered
                        mute_reg <= 1'b1;
                        state_reg <= is_end ? cfg_msg_pkg::ST_DECIDE : cfg_msg_pkg::ST_SKIP;
                    end else if (rx_fire) begin
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == cfg_msg_pkg::RID_LAST) begin
                            cnt_reg <= '0;
                            state_reg <= cfg_msg_pkg::ST_REG;
                        end
                    end
                end
                cfg_msg_pkg::ST_REG, cfg_msg_pkg::ST_SIZE, cfg_msg_pkg::ST_DATA: begin
                    if (rx_fire && rx_tok_in.ctrl) begin
                        bad_reg <= 1'b1;
                        state_reg <= is_end ? cfg_msg_pkg::ST_DECIDE : cfg_msg_pkg::ST_SKIP;
                    end else if (rx_fire) begin
                        cnt_reg <= cnt_reg + 3'h1;
                        if (state_reg == cfg_msg_pkg::ST_REG
                                && cnt_reg == (periph ? cfg_msg_pkg::REG_LAST_PER : cfg_msg_pkg::REG_LAST_CFG)) begin
                            cnt_reg <= '0;
                            state_reg <= periph ? cfg_msg_pkg::ST_SIZE
                                : (write_reg ? cfg_msg_pkg::ST_DATA : cfg_msg_pkg::ST_END);
                        end else if (state_reg == cfg_msg_pkg::ST_SIZE) begin
                            if (rx_tok_in.data == 8'h00 || rx_tok_in.data > cfg_msg_pkg::SIZE_MAX) begin
                                bad_reg <= 1'b1;
                            end
                            state_reg <= cfg_msg_pkg::ST_END;
                        end else if (state_reg == cfg_msg_pkg::ST_DATA && cnt_reg == cfg_msg_pkg::DATA_LAST) begin
                            state_reg <= cfg_msg_pkg::ST_END;
                        end
                    end
                end
                cfg_msg_pkg::ST_END: begin
                    if (rx_fire && is_end) begin
                        state_reg <= cfg_msg_pkg::ST_DECIDE;
                    end else if (rx_fire) begin
                        bad_reg <= 1'b1;
                        state_reg <= cfg_msg_pkg::ST_SKIP;
                    end
                end
                cfg_msg_pkg::ST_SKIP: begin
                    if (rx_fire && is_end) begin
                        state_reg <= cfg_msg_pkg::ST_DECIDE;
                    end
                end
                cfg_msg_pkg::ST_DECIDE: begin
                    if (bad_reg || mute_reg) begin
                        ok_reg <= 1'b0;
                        state_reg <= cfg_msg_pkg::ST_REPLY;
                    end else begin
                        acc_valid_reg <= 1'b1;
                        state_reg <= cfg_msg_pkg::ST_WAIT;
                    end
                end
                cfg_msg_pkg::ST_WAIT: begin
                    if (acc_done_in) begin
                        ok_reg <= acc_ok_in;
                        state_reg <= cfg_msg_pkg::ST_REPLY;
                    end
                end
                cfg_msg_pkg::ST_REPLY: begin
                    if (mute_reg || (write_reg && rid_reg[7:0] == cfg_msg_pkg::NOREPLY_LOW)) begin
                        state_reg <= cfg_msg_pkg::ST_IDLE;
                    end else begin
                        tx_valid_reg <= 1'b1;
                        tx_tok_reg <= {1'b1, ok_reg ? cfg_msg_pkg::TOK_ACK : cfg_msg_pkg::TOK_NACK};
                        tx_left_reg <= (ok_reg && !write_reg) ? reply_len : 3'h0;
                        state_reg <= cfg_msg_pkg::ST_TX;
                    end
                end
                cfg_msg_pkg::ST_TX: begin
                    if (tx_fire) begin
                        if (tx_tok_reg.ctrl && tx_tok_reg.data == cfg_msg_pkg::TOK_END) begin
                            tx_valid_reg <= 1'b0;
                            state_reg <= cfg_msg_pkg::ST_IDLE;
                        end else if (tx_left_reg != 3'h0) begin
                            tx_tok_reg <= {1'b0, rdata_reg[31:24]};
                            tx_left_reg <= tx_left_reg - 3'h1;
                        end else begin
                            tx_tok_reg <= {1'b1, cfg_msg_pkg::TOK_END};
                        end
                    end
                end
                default: begin
                    state_reg <= cfg_msg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // field capture, most significant byte arriving first
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rid_reg <= '0;
            reg_num_reg <= '0;
            wdata_reg <= '0;
            size_reg <= '0;
        end else if (rx_fire && rx_tok_in.ctrl && state_reg == cfg_msg_pkg::ST_IDLE) begin
            // an 8-bit peripheral number must not inherit the last request's low byte as its high byte
            reg_num_reg <= '0;
        end else if (rx_fire && !rx_tok_in.ctrl) begin
            if (state_reg == cfg_msg_pkg::ST_RID) begin
                rid_reg <= 24'(push_byte({8'h00, rid_reg}, rx_tok_in.data));
            end
            if (state_reg == cfg_msg_pkg::ST_REG) begin
                reg_num_reg <= 16'(push_byte({16'h0000, reg_num_reg}, rx_tok_in.data));
            end
            if (state_reg == cfg_msg_pkg::ST_SIZE) begin
                size_reg <= rx_tok_in.data;
            end
            if (state_reg == cfg_msg_pkg::ST_DATA) begin
                wdata_reg <= push_byte(wdata_reg, rx_tok_in.data);
            end
        end
    end

    // read data held left-aligned so each send takes the top byte
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= '0;
        end else if (state_reg == cfg_msg_pkg::ST_WAIT && acc_done_in) begin
            rdata_reg <= align_top(acc_rdata_in, reply_len);
        end else if (state_reg == cfg_msg_pkg::ST_TX && tx_fire && tx_left_reg != 3'h0) begin
            // shift as the top byte is loaded, or the first data byte goes out twice
            rdata_reg <= {rdata_reg[23:0], 8'h00};
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_req_out <= '0;
        end else if (state_reg == cfg_msg_pkg::ST_DECIDE) begin
            acc_req_out <= '{write: write_reg, space: space_reg, reg_num: reg_num_reg,
                wdata: wdata_reg, size: size_reg};
        end
    end

    // processor-status instruction port: one word per instruction
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ps_valid_out <= 1'b0;
            ps_bad_out <= 1'b0;
            ps_req_out <= '0;
        end else begin
            ps_valid_out <= ps_cmd_valid_in && (ps_cmd_resid_in[7:0] == cfg_msg_pkg::PS_TYPE);
            ps_bad_out <= ps_cmd_valid_in && (ps_cmd_resid_in[7:0] != cfg_msg_pkg::PS_TYPE);
            if (ps_cmd_valid_in) begin
                ps_req_out <= '{write: ps_cmd_write_in, reg_num: 24'(ps_cmd_resid_in >> cfg_msg_pkg::PS_SHIFT),
                    wdata: ps_cmd_wdata_in};
            end
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence status_sent_s;
        tx_fire && tx_tok_reg.ctrl && (tx_tok_reg.data == cfg_msg_pkg::TOK_ACK);
    endsequence
    sequence read_ok_s;
        status_sent_s ##0 (tx_left_reg != 3'h0);
    endsequence

    reply_dest_a: assert property (tx_valid_out |-> $stable(tx_dest_out))
        else $error("reply address moved during reply");
    no_reply_a: assert property (state_reg == cfg_msg_pkg::ST_REPLY && write_reg
        && rid_reg[7:0] == cfg_msg_pkg::NOREPLY_LOW |=> state_reg == cfg_msg_pkg::ST_IDLE && !tx_valid_out)
        else $error("suppressed write still replied");
    reg_order_a: assert property (rx_fire && !rx_tok_in.ctrl && state_reg == cfg_msg_pkg::ST_REG
        |=> reg_num_reg == {$past(reg_num_reg[7:0]), $past(rx_tok_in.data)})
        else $error("register number not msb first");
    ps_decode_a: assert property (ps_cmd_valid_in && ps_cmd_resid_in[7:0] == cfg_msg_pkg::PS_TYPE
        |=> ps_valid_out && ps_req_out.reg_num == $past(ps_cmd_resid_in[31:8]))
        else $error("status id decoded wrongly");
    ps_word_a: assert property (ps_valid_out && ps_req_out.write |-> ps_req_out.wdata == $past(ps_cmd_wdata_in))
        else $error("status write word lost");
    status_first_a: assert property ($rose(tx_valid_out) |-> tx_tok_out.ctrl
        && (tx_tok_out.data == cfg_msg_pkg::TOK_ACK || tx_tok_out.data == cfg_msg_pkg::TOK_NACK))
        else $error("reply does not open with status token");
    fail_close_a: assert property (tx_fire && tx_tok_out.ctrl && tx_tok_out.data == cfg_msg_pkg::TOK_NACK
        |=> tx_valid_out && tx_tok_out == {1'b1, cfg_msg_pkg::TOK_END})
        else $error("failure reply not closed by end token");
    read_data_a: assert property (read_ok_s |=> tx_valid_out && !tx_tok_out.ctrl)
        else $error("successful read reply lacks data");
    write_req_a: assert property (acc_valid_out && acc_req_out.write |-> acc_req_out.wdata == wdata_reg
        && acc_req_out.space != cfg_msg_pkg::SPACE_PERIPH)
        else $error("write request carries wrong data");
    per_size_a: assert property (acc_valid_out && acc_req_out.space == cfg_msg_pkg::SPACE_PERIPH
        |-> acc_req_out.size != 8'h00 && acc_req_out.size <= cfg_msg_pkg::SIZE_MAX)
        else $error("peripheral size out of range");
    bad_open_a: assert property (rx_fire && state_reg == cfg_msg_pkg::ST_IDLE && rx_tok_in.ctrl
        && rx_tok_in.data != cfg_msg_pkg::TOK_WRITE && rx_tok_in.data != cfg_msg_pkg::TOK_READ
        && rx_tok_in.data != cfg_msg_pkg::TOK_PREAD |=> bad_reg ##1 !acc_valid_out[*3])
        else $error("unknown opening token accepted");
endmodule

`default_nettype wire

// ### src/cfg_msg_pkg.sv
// constants, tokens and carrier types for the configuration message interpreter
package cfg_msg_pkg;
    localparam logic [7:0] TOK_WRITE = 8'hC0;
    localparam logic [7:0] TOK_READ = 8'hC1;
    localparam logic [7:0] TOK_PREAD = 8'h25;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NACK = 8'h04;
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] NOREPLY_LOW = 8'hFF;
    localparam logic [7:0] PS_TYPE = 8'h0B;
    localparam int PS_SHIFT = 8;
    localparam logic [2:0] RID_LAST = 3'h2;
    localparam logic [2:0] REG_LAST_CFG = 3'h1;
    localparam logic [2:0] REG_LAST_PER = 3'h0;
    localparam logic [2:0] DATA_LAST = 3'h3;
    localparam logic [2:0] WORD_BYTES = 3'h4;
    localparam logic [7:0] SIZE_MAX = 8'h04;

    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } token_t;

    typedef enum logic [1:0] {SPACE_TILE, SPACE_NODE, SPACE_PERIPH, SPACE_NONE} space_t;

    typedef struct packed {
        logic write;
        space_t space;
        logic [15:0] reg_num;
        logic [31:0] wdata;
        logic [7:0] size;
    } acc_req_t;

    typedef struct packed {
        logic write;
        logic [23:0] reg_num;
        logic [31:0] wdata;
    } ps_req_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RID, ST_REG, ST_SIZE, ST_DATA, ST_END, ST_SKIP, ST_DECIDE, ST_WAIT, ST_REPLY, ST_TX
    } state_t;
endpackage
